// [logic/timer16_params.svh]
// Offsets, field positions, reset values and mode codes of the 16-bit timer.
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define T16_ADDR_W        4
`define T16_OFF_CTRL_A    4'h0
`define T16_OFF_CTRL_B    4'h1
`define T16_OFF_CNT_LO    4'h2
`define T16_OFF_CNT_HI    4'h3
`define T16_OFF_CMPA_LO   4'h4
`define T16_OFF_CMPA_HI   4'h5
`define T16_OFF_CMPB_LO   4'h6
`define T16_OFF_CMPB_HI   4'h7
`define T16_OFF_FLAGS     4'h8
`define T16_A_MODE_A_POS  6
`define T16_A_MODE_B_POS  4
`define T16_A_FORCE_A     3
`define T16_A_FORCE_B     2
`define T16_A_WAVE_LO_POS 0
`define T16_B_WAVE_HI_POS 3
`define T16_B_CLKSEL_POS  0
`define T16_F_OVF         0
`define T16_F_MATCH_A     1
`define T16_F_MATCH_B     2
`define T16_RST_BYTE      8'h00
`define T16_RST_WORD      16'h0000
`define T16_MAX           16'hFFFF
`define T16_TOP_8BIT      16'h00FF
`define T16_TOP_9BIT      16'h01FF
`define T16_TOP_10BIT     16'h03FF
`define T16_CLKSEL_STOP   3'h0
`define T16_WM_NORMAL     4'h0
`define T16_WM_PC8        4'h1
`define T16_WM_PC9        4'h2
`define T16_WM_PC10       4'h3
`define T16_WM_CTC        4'h4
`define T16_WM_FP8        4'h5
`define T16_WM_FP9        4'h6
`define T16_WM_FP10       4'h7
`define T16_WM_PFC_FIX    4'h8
`define T16_WM_PFC_CMP    4'h9
`define T16_WM_PC_FIX     4'hA
`define T16_WM_PC_CMP     4'hB
`define T16_WM_CTC_FIX    4'hC
`define T16_WM_FP_FIX     4'hE
`define T16_WM_FP_CMP     4'hF
`define T16_OM_OFF        2'h0
`define T16_OM_TOGGLE     2'h1
`define T16_OM_CLEAR      2'h2
`define T16_OM_SET        2'h3
`endif

// [logic/timer16_pkg.sv]
// Types shared by the 16-bit timer modules.
`default_nettype none
`include "timer16_params.svh"
package timer16_pkg;
  // One CPU I/O bus request, taken in the cycle it is presented.
  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic [`T16_ADDR_W-1:0]   addr;
    logic [7:0]               wdata;
  } io_req_s;
  // Counting behaviour decoded from the waveform mode field.
  typedef struct packed {
    logic [15:0] top;
    logic        pwm;
    logic        dual;
    logic        ovf_at_floor;
    logic        load_at_floor;
  } mode_info_s;
  // Counting direction.
  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;
endpackage
`default_nettype wire

// [logic/timer16_mode_decode.sv]
// Decoder from the waveform mode field to the counting sequence.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"
module timer16_mode_decode (
  input  wire logic [3:0]             wave_mode,
  input  wire logic [15:0]            compare_a,
  output var  timer16_pkg::mode_info_s info
);
  // Top value, slope count and update points of each mode.
  always_comb begin
    info = '{top: `T16_MAX, pwm: 1'b0, dual: 1'b0,
             ovf_at_floor: 1'b0, load_at_floor: 1'b0};
    case (wave_mode)
      `T16_WM_PC8, `T16_WM_FP8: info.top = `T16_TOP_8BIT;
      `T16_WM_PC9, `T16_WM_FP9: info.top = `T16_TOP_9BIT;
      `T16_WM_PC10, `T16_WM_FP10: info.top = `T16_TOP_10BIT;
      `T16_WM_CTC, `T16_WM_PFC_CMP, `T16_WM_PC_CMP,
      `T16_WM_FP_CMP: info.top = compare_a;
      default: info.top = `T16_MAX;
    endcase
    case (wave_mode)
      `T16_WM_NORMAL, `T16_WM_CTC, `T16_WM_CTC_FIX, 4'hD: info.pwm = 1'b0;
      default: info.pwm = 1'b1;
    endcase
    case (wave_mode)
      `T16_WM_PC8, `T16_WM_PC9, `T16_WM_PC10, `T16_WM_PFC_FIX,
      `T16_WM_PFC_CMP, `T16_WM_PC_FIX, `T16_WM_PC_CMP: begin
        info.dual         = 1'b1;
        info.ovf_at_floor = 1'b1;
      end
      default: info.dual = 1'b0;
    endcase
    info.load_at_floor = (wave_mode == `T16_WM_PFC_FIX) ||
                         (wave_mode == `T16_WM_PFC_CMP);
  end
endmodule // timer16_mode_decode
`default_nettype wire

// [logic/timer16_compare_chan.sv]
// One compare channel: compare value, its buffer and the output state.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"
module timer16_compare_chan (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    wr_low,
  input  wire logic [7:0]              wdata,
  input  wire logic [7:0]              temp,
  input  wire logic                    tick,
  input  wire logic                    tick_top,
  input  wire logic                    load_now,
  input  wire logic [15:0]             count,
  input  wire logic                    blocked,
  input  wire logic                    down,
  input  wire logic                    force_pulse,
  input  wire logic [1:0]              output_mode,
  input  wire timer16_pkg::mode_info_s info,
  output logic [15:0]                  compare_value,
  output logic                         hit,
  output logic                         out_level
);
  logic [15:0] buffer;

  // A real match needs a tick, equality and no pending block.
  assign hit = tick && !blocked && (count == compare_value);

  // Low byte write copies the shared latch into the upper byte.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buffer <= `T16_RST_WORD;
    end else if (ce && wr_low) begin
      buffer <= {temp, wdata};
    end
  end

  // Non-PWM modes load at once; PWM modes load at the update point.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      compare_value <= `T16_RST_WORD;
    end else if (ce) begin
      if (wr_low && !info.pwm) begin
        compare_value <= {temp, wdata};
      end else if (info.pwm && load_now) begin
        compare_value <= buffer;
      end
    end
  end

  // Output state; the mode field is used live, never buffered.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_level <= 1'b0;
    end else if (ce) begin
      if ((force_pulse && !info.pwm) || (hit && !info.pwm)) begin
        case (output_mode)
          `T16_OM_TOGGLE: out_level <= !out_level;
          `T16_OM_CLEAR:  out_level <= 1'b0;
          `T16_OM_SET:    out_level <= 1'b1;
          default:        out_level <= out_level;
        endcase
      end else if (hit) begin
        if (output_mode == `T16_OM_CLEAR) begin
          out_level <= info.dual && down;
        end else if (output_mode == `T16_OM_SET) begin
          out_level <= !(info.dual && down);
        end
      end else if (info.pwm && !info.dual && tick_top) begin
        if (output_mode == `T16_OM_CLEAR) begin
          out_level <= 1'b1;
        end else if (output_mode == `T16_OM_SET) begin
          out_level <= 1'b0;
        end
      end
    end
  end
endmodule // timer16_compare_chan
`default_nettype wire

// [logic/timer16_counter_compare.sv]
// Sixteen-bit timer/counter with two compare channels on an 8-bit I/O bus.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"

// Notes on behaviour
// - Counter appears as two byte locations, upper byte and lower byte.
// - Counter high-byte accesses only reach the shared high-byte latch.
// - Reading the counter low byte loads its upper byte into the latch.
// - Writing the counter low byte loads latch and low byte together.
// - Each tick clears, increments or decrements the counter per mode.
// - Clock select zero stops ticks; CPU access to the counter remains.
// - A CPU counter write beats any same-cycle clear or count.
// - Four-bit waveform mode, split over both control registers, sets sequence.
// - Overflow flag set where the mode says; it requests an interrupt.
// - Internal indications mark counter at top and counter at zero.
// - Compare low byte write copies latch into upper compare byte.
// - In non-PWM modes the force strobe triggers the match output.
// - Forced compare skips flag and counter but drives the output.
// - A counter write blocks every compare match on the next tick.
// - Compare output state survives a change of waveform mode.
// - Output mode field is not buffered and acts at once.
module timer16_counter_compare (
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 CE,
  input  wire logic                 TICK,
  input  wire timer16_pkg::io_req_s IO_REQ,
  output logic [7:0]                IO_RDATA,
  output logic                      OUT_A,
  output logic                      OUT_B,
  output logic                      OVF_IRQ,
  output logic                      MATCH_A_IRQ,
  output logic                      MATCH_B_IRQ,
  output logic                      AT_TOP,
  output logic                      AT_FLOOR
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------

  localparam int CHANNELS = 2;

  logic [1:0]              output_mode [CHANNELS];
  logic [3:0]              wave_mode;
  logic [1:0]              wave_lo;
  logic [1:0]              wave_hi;
  logic [2:0]              clock_select_field;
  logic [7:0]              temp;
  logic [15:0]             count_value;
  logic [15:0]             next_count;
  timer16_pkg::dir_e       dir;
  timer16_pkg::dir_e       next_dir;
  logic                    blocked;
  logic                    overflow_flag;
  logic [CHANNELS-1:0]     compare_match_flag;
  timer16_pkg::mode_info_s info;
  logic                    tick;
  logic                    tick_top;
  logic                    tick_floor;
  logic                    load_now;
  logic                    ovf_event;
  logic                    wr_ctrl_a;
  logic                    wr_ctrl_b;
  logic                    wr_cnt_lo;
  logic                    rd_cnt_lo;
  logic                    wr_temp;
  logic                    wr_flags;
  logic [CHANNELS-1:0]     wr_cmp_lo;
  logic [CHANNELS-1:0]     force_pulse;
  logic [CHANNELS-1:0]     hit;
  logic [CHANNELS-1:0]     out_level;
  logic [15:0]             compare_value [CHANNELS];

  // ---------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------

  // True when the request addresses the given location.
  function automatic logic hits(
    input timer16_pkg::io_req_s req,
    input logic [`T16_ADDR_W-1:0] off
  );
    hits = (req.addr == off);
  endfunction

  // Write and read strobes of the individual locations.
  assign wr_ctrl_a = IO_REQ.wr && hits(IO_REQ, `T16_OFF_CTRL_A);
  assign wr_ctrl_b = IO_REQ.wr && hits(IO_REQ, `T16_OFF_CTRL_B);
  assign wr_cnt_lo = IO_REQ.wr && hits(IO_REQ, `T16_OFF_CNT_LO);
  assign rd_cnt_lo = IO_REQ.rd && hits(IO_REQ, `T16_OFF_CNT_LO);
  assign wr_flags  = IO_REQ.wr && hits(IO_REQ, `T16_OFF_FLAGS);
  assign wr_cmp_lo[0] = IO_REQ.wr && hits(IO_REQ, `T16_OFF_CMPA_LO);
  assign wr_cmp_lo[1] = IO_REQ.wr && hits(IO_REQ, `T16_OFF_CMPB_LO);

  // Every high-byte write, counter or compare, lands in the one latch.
  assign wr_temp = IO_REQ.wr && (hits(IO_REQ, `T16_OFF_CNT_HI) ||
                   hits(IO_REQ, `T16_OFF_CMPA_HI) ||
                   hits(IO_REQ, `T16_OFF_CMPB_HI));

  // Force strobes exist only for the write cycle; they are not stored.
  assign force_pulse[0] = wr_ctrl_a && IO_REQ.wdata[`T16_A_FORCE_A];
  assign force_pulse[1] = wr_ctrl_a && IO_REQ.wdata[`T16_A_FORCE_B];

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------

  // Control A holds both output mode fields and the low mode bits.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      output_mode[0] <= `T16_OM_OFF;
      output_mode[1] <= `T16_OM_OFF;
      wave_lo        <= 2'h0;
    end else if (CE && wr_ctrl_a) begin
      output_mode[0] <= IO_REQ.wdata[`T16_A_MODE_A_POS +: 2];
      output_mode[1] <= IO_REQ.wdata[`T16_A_MODE_B_POS +: 2];
      wave_lo        <= IO_REQ.wdata[`T16_A_WAVE_LO_POS +: 2];
    end
  end

  // Control B holds the high mode bits and the clock select field.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wave_hi            <= 2'h0;
      clock_select_field <= `T16_CLKSEL_STOP;
    end else if (CE && wr_ctrl_b) begin
      wave_hi            <= IO_REQ.wdata[`T16_B_WAVE_HI_POS +: 2];
      clock_select_field <= IO_REQ.wdata[`T16_B_CLKSEL_POS +: 3];
    end
  end

  // The two halves of the mode field, each owned by one register, join.
  assign wave_mode = {wave_hi, wave_lo};

  // Mode decoder shared by the counter and both channels.
  timer16_mode_decode u_decode (
    .wave_mode (wave_mode),
    .compare_a (compare_value[0]),
    .info      (info)
  );

  // ---------------------------------------------------------------
  // Shared high-byte latch
  // ---------------------------------------------------------------

  // Loaded by high-byte writes, or from the counter on a low-byte read.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      temp <= `T16_RST_BYTE;
    end else if (CE) begin
      if (wr_temp) begin
        temp <= IO_REQ.wdata;
      end else if (rd_cnt_lo) begin
        temp <= count_value[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter unit
  // ---------------------------------------------------------------

  // A tick only counts while a clock source is selected.
  assign tick = TICK && CE &&
                (clock_select_field != `T16_CLKSEL_STOP);

  // Tick events at the ends of the sequence.
  assign tick_top   = tick && (count_value == info.top);
  assign tick_floor = tick && (count_value == `T16_RST_WORD);
  assign load_now   = info.load_at_floor ? tick_floor : tick_top;

  // Next counter value and direction for a tick.
  always_comb begin
    next_count = count_value;
    next_dir   = dir;
    if (!info.dual) begin
      next_dir = timer16_pkg::DIR_UP;
      if (count_value == info.top) begin
        next_count = `T16_RST_WORD;
      end else begin
        next_count = count_value + 16'h0001;
      end
    end else if (dir == timer16_pkg::DIR_UP) begin
      if (count_value == info.top) begin
        next_dir   = timer16_pkg::DIR_DOWN;
        next_count = count_value - 16'h0001;
      end else begin
        next_count = count_value + 16'h0001;
      end
    end else begin
      if (count_value == `T16_RST_WORD) begin
        next_dir   = timer16_pkg::DIR_UP;
        next_count = count_value + 16'h0001;
      end else begin
        next_count = count_value - 16'h0001;
      end
    end
  end

  // The CPU write wins over any count scheduled in the same cycle.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      count_value <= `T16_RST_WORD;
    end else if (CE) begin
      if (wr_cnt_lo) begin
        count_value <= {temp, IO_REQ.wdata};
      end else if (tick) begin
        count_value <= next_count;
      end
    end
  end

  // Direction follows the sequence; a write leaves it as it stands.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dir <= timer16_pkg::DIR_UP;
    end else if (CE && tick && !wr_cnt_lo) begin
      dir <= next_dir;
    end
  end

  // A counter write arms a block that the next tick consumes.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      blocked <= 1'b0;
    end else if (CE) begin
      if (wr_cnt_lo) begin
        blocked <= 1'b1;
      end else if (tick) begin
        blocked <= 1'b0;
      end
    end
  end

  // Top and floor indications track the value the counter takes.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      AT_TOP   <= 1'b0;
      AT_FLOOR <= 1'b1;
    end else if (CE) begin
      if (wr_cnt_lo) begin
        AT_TOP   <= ({temp, IO_REQ.wdata} == info.top);
        AT_FLOOR <= ({temp, IO_REQ.wdata} == `T16_RST_WORD);
      end else if (tick) begin
        AT_TOP   <= (next_count == info.top);
        AT_FLOOR <= (next_count == `T16_RST_WORD);
      end
    end
  end

  // ---------------------------------------------------------------
  // Overflow and match flags
  // ---------------------------------------------------------------

  // Overflow point: floor for dual slope, top for PWM, else maximum.
  assign ovf_event = tick && (info.ovf_at_floor ?
                     (count_value == `T16_RST_WORD &&
                      dir == timer16_pkg::DIR_DOWN) :
                     (count_value == (info.pwm ? info.top : `T16_MAX)));

  // Set by the event, cleared by writing one; the event wins.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      overflow_flag <= 1'b0;
    end else if (CE) begin
      if (ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (wr_flags && IO_REQ.wdata[`T16_F_OVF]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Match flags follow real matches only, never forced ones.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      compare_match_flag <= '0;
    end else if (CE) begin
      if (hit[0]) begin
        compare_match_flag[0] <= 1'b1;
      end else if (wr_flags && IO_REQ.wdata[`T16_F_MATCH_A]) begin
        compare_match_flag[0] <= 1'b0;
      end
      if (hit[1]) begin
        compare_match_flag[1] <= 1'b1;
      end else if (wr_flags && IO_REQ.wdata[`T16_F_MATCH_B]) begin
        compare_match_flag[1] <= 1'b0;
      end
    end
  end

  // Interrupt requests are the flags themselves.
  assign OVF_IRQ     = overflow_flag;
  assign MATCH_A_IRQ = compare_match_flag[0];
  assign MATCH_B_IRQ = compare_match_flag[1];

  // ---------------------------------------------------------------
  // Compare channels
  // ---------------------------------------------------------------

  // One compare unit per channel; the output state is never reset by
  // a mode change, only by the block reset.
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    timer16_compare_chan u_chan (
      .clk           (CLK),
      .resetn        (RESETN),
      .ce            (CE),
      .wr_low        (wr_cmp_lo[g]),
      .wdata         (IO_REQ.wdata),
      .temp          (temp),
      .tick          (tick),
      .tick_top      (tick_top),
      .load_now      (load_now),
      .count         (count_value),
      .blocked       (blocked),
      .down          (dir == timer16_pkg::DIR_DOWN),
      .force_pulse   (force_pulse[g]),
      .output_mode   (output_mode[g]),
      .info          (info),
      .compare_value (compare_value[g]),
      .hit           (hit[g]),
      .out_level     (out_level[g])
    );
  end

  // Compare outputs come straight from the channel state flops.
  assign OUT_A = out_level[0];
  assign OUT_B = out_level[1];

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------

  // Read data appears the cycle after an enabled read, is zero after other enabled cycles and holds while CE is low.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      IO_RDATA <= `T16_RST_BYTE;
    end else if (CE) begin
      IO_RDATA <= `T16_RST_BYTE;
      if (IO_REQ.rd) begin
        case (IO_REQ.addr)
          `T16_OFF_CTRL_A:  IO_RDATA <= {output_mode[0], output_mode[1],
                                         2'h0, wave_mode[1:0]};
          `T16_OFF_CTRL_B:  IO_RDATA <= {3'h0, wave_mode[3:2],
                                         clock_select_field};
          `T16_OFF_CNT_LO:  IO_RDATA <= count_value[7:0];
          `T16_OFF_CNT_HI:  IO_RDATA <= temp;
          `T16_OFF_CMPA_LO: IO_RDATA <= compare_value[0][7:0];
          `T16_OFF_CMPA_HI: IO_RDATA <= compare_value[0][15:8];
          `T16_OFF_CMPB_LO: IO_RDATA <= compare_value[1][7:0];
          `T16_OFF_CMPB_HI: IO_RDATA <= compare_value[1][15:8];
          `T16_OFF_FLAGS:   IO_RDATA <= {5'h00, compare_match_flag,
                                         overflow_flag};
          default:          IO_RDATA <= `T16_RST_BYTE;
        endcase
      end
    end
  end

endmodule // timer16_counter_compare
`default_nettype wire

// [dv/timer16_cpu_model.sv]
// CPU core model that drives the timer's 8-bit I/O bus.
`timescale 1ns/10ps
`default_nettype none
module timer16_cpu_model (
  input  wire logic                 clk,
  input  wire logic [7:0]           rdata,
  output var  timer16_pkg::io_req_s req
);
  // ---------------------------
  // Bus cycles
  // ---------------------------
  initial req = '0;
  // Writes for one edge; idle fields then carry the inverse of the last.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Reads for one edge; the answer is taken one cycle later.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~a, 8'hFF};
    d = rdata;
  endtask
endmodule // timer16_cpu_model
`default_nettype wire

// [dv/timer16_counter_compare_checker.sv]
// Port assertions for the 16-bit timer/counter.
`timescale 1ns/10ps
`default_nettype none
module timer16_counter_compare_checker (
  input wire logic                 CLK,
  input wire logic                 RESETN,
  input wire logic                 CE,
  input wire logic                 TICK,
  input wire timer16_pkg::io_req_s IO_REQ,
  input wire logic [7:0]           IO_RDATA,
  input wire logic                 OUT_A,
  input wire logic                 OVF_IRQ,
  input wire logic                 MATCH_A_IRQ,
  input wire logic                 AT_FLOOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_unmapped_read:
    assert property (CE && IO_REQ.rd && IO_REQ.addr > 4'h8 |=>
      IO_RDATA == 8'h00) else $error("Unmapped read gave data.");
  chk_floor_left:
    assert property (CE && IO_REQ.wr && IO_REQ.addr == 4'h2 &&
      IO_REQ.wdata != 8'h00 |=> !AT_FLOOR) else $error("Floor stuck.");
  chk_ovf_sticky:
    assert property (OVF_IRQ && !(CE && IO_REQ.wr && IO_REQ.addr == 4'h8
      && IO_REQ.wdata[0]) |=> OVF_IRQ) else $error("Overflow lost.");
  chk_match_clear:
    assert property (CE && !TICK && IO_REQ.wr && IO_REQ.addr == 4'h8 &&
      IO_REQ.wdata[1] |=> !MATCH_A_IRQ) else $error("Match not cleared.");
  chk_flag_tickless:
    assert property (CE && !TICK && !MATCH_A_IRQ |=> !MATCH_A_IRQ)
      else $error("Match flag without tick.");
  chk_frozen_state:
    assert property (!CE |=> $stable(OUT_A) && $stable(OVF_IRQ))
      else $error("State moved while disabled.");
  chk_out_cause:
    assert property (CE && !TICK && !(IO_REQ.wr && IO_REQ.addr == 4'h0)
      |=> $stable(OUT_A)) else $error("Output changed without cause.");
  chk_block_tick:
    assert property (CE && IO_REQ.wr && IO_REQ.addr == 4'h2 && !TICK &&
      !MATCH_A_IRQ ##1 CE && !TICK && !IO_REQ.wr
      ##1 CE && TICK && !IO_REQ.wr |=> !MATCH_A_IRQ)
      else $error("Match after counter write.");
endmodule // timer16_counter_compare_checker
bind timer16_counter_compare timer16_counter_compare_checker
  timer16_counter_compare_checker_i (.CLK(CLK), .RESETN(RESETN),
  .CE(CE), .TICK(TICK), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA),
  .OUT_A(OUT_A), .OVF_IRQ(OVF_IRQ), .MATCH_A_IRQ(MATCH_A_IRQ),
  .AT_FLOOR(AT_FLOOR));
`default_nettype wire

// [dv/timer16_counter_compare_tb.sv]
// Self-checking bench for the 16-bit timer/counter.
`timescale 1ns/10ps
`default_nettype none
module timer16_counter_compare_tb;
  logic                 clk;
  logic                 resetn;
  logic                 ce;
  logic                 tick;
  timer16_pkg::io_req_s io_req;
  logic [7:0]           io_rdata;
  logic                 out_a;
  logic                 out_b;
  logic                 at_top;
  logic                 at_floor;
  logic [2:0]           irq;
  int                   num_errors;
  int                   check_count;
  timer16_counter_compare timer16_counter_compare_i (.CLK(clk),
    .RESETN(resetn), .CE(ce), .TICK(tick), .IO_REQ(io_req),
    .IO_RDATA(io_rdata), .OUT_A(out_a), .OUT_B(out_b), .OVF_IRQ(irq[0]),
    .MATCH_A_IRQ(irq[1]), .MATCH_B_IRQ(irq[2]), .AT_TOP(at_top),
    .AT_FLOOR(at_floor));
  timer16_cpu_model timer16_cpu_model_i (.clk(clk), .rdata(io_rdata),
    .req(io_req));
  // ---------------------------
  // Helpers
  // ---------------------------
  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Reads one location and compares it.
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    timer16_cpu_model_i.rd(a, d);
    chk(d, e);
  endtask
  // Gives n single-cycle ticks.
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  // ---------------------------
  // Scenarios
  // ---------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    tick = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    for (int a = 0; a < 10; a++) rdc(a[3:0], 8'h00);
    chk({7'h00, at_floor}, 8'h01);
    timer16_cpu_model_i.wr(4'h3, 8'h12);
    timer16_cpu_model_i.wr(4'h2, 8'h34);
    rdc(4'h2, 8'h34);
    rdc(4'h3, 8'h12);
    timer16_cpu_model_i.wr(4'h3, 8'h56);
    rdc(4'h3, 8'h56);
    rdc(4'h2, 8'h34);
    rdc(4'h3, 8'h12);
    pulse(3);
    rdc(4'h2, 8'h34);
    timer16_cpu_model_i.wr(4'h1, 8'h01);
    ce = 1'b0;
    pulse(2);
    ce = 1'b1;
    rdc(4'h2, 8'h34);
    pulse(3);
    rdc(4'h2, 8'h37);
    timer16_cpu_model_i.wr(4'h3, 8'h02);
    tick = 1'b1;
    timer16_cpu_model_i.wr(4'h2, 8'h00);
    tick = 1'b0;
    rdc(4'h2, 8'h00);
    rdc(4'h3, 8'h02);
    timer16_cpu_model_i.wr(4'h3, 8'hFF);
    timer16_cpu_model_i.wr(4'h2, 8'hFF);
    chk({6'h00, at_top, at_floor}, 8'h02);
    pulse(1);
    chk({6'h00, at_top, at_floor}, 8'h01);
    chk({5'h00, irq}, 8'h01);
    rdc(4'h8, 8'h01);
    timer16_cpu_model_i.wr(4'h8, 8'h07);
    rdc(4'h8, 8'h00);
    timer16_cpu_model_i.wr(4'h0, 8'h50);
    timer16_cpu_model_i.wr(4'h5, 8'h01);
    timer16_cpu_model_i.wr(4'h4, 8'h05);
    rdc(4'h5, 8'h01);
    timer16_cpu_model_i.wr(4'h7, 8'h01);
    timer16_cpu_model_i.wr(4'h6, 8'h05);
    rdc(4'h7, 8'h01);
    timer16_cpu_model_i.wr(4'h3, 8'h01);
    timer16_cpu_model_i.wr(4'h2, 8'h05);
    pulse(1);
    rdc(4'h8, 8'h00);
    timer16_cpu_model_i.wr(4'h3, 8'h01);
    timer16_cpu_model_i.wr(4'h2, 8'h04);
    pulse(2);
    rdc(4'h8, 8'h06);
    chk({7'h00, out_a}, 8'h01);
    chk({7'h00, out_b}, 8'h01);
    chk({5'h00, irq}, 8'h06);
    timer16_cpu_model_i.wr(4'h8, 8'h07);
    timer16_cpu_model_i.wr(4'h0, 8'h48);
    chk({7'h00, out_a}, 8'h00);
    rdc(4'h8, 8'h00);
    rdc(4'h2, 8'h06);
    timer16_cpu_model_i.wr(4'h0, 8'hC8);
    chk({7'h00, out_a}, 8'h01);
    timer16_cpu_model_i.wr(4'h0, 8'h81);
    chk({7'h00, out_a}, 8'h01);
    timer16_cpu_model_i.wr(4'h0, 8'h89);
    chk({7'h00, out_a}, 8'h01);
    timer16_cpu_model_i.wr(4'h3, 8'h00);
    timer16_cpu_model_i.wr(4'h2, 8'hFE);
    pulse(1);
    chk({6'h00, at_top, at_floor}, 8'h02);
    pulse(1);
    rdc(4'h2, 8'hFE);
    results();
  end
endmodule // timer16_counter_compare_tb
`default_nettype wire
